// File: hw/mst_modem_status_tracker.v
// Purpose: modem status register bank of a single-channel UART, with change
//          flags, loopback mirroring, clear-to-send flow gate and interrupt
// Assumes: AHB-Lite slave, one clock CORE_CLK, asynchronous active-low reset
// Notes:   reads take one wait state; writes take none
//
// Contract
// - a change of a monitored modem input sets its change flag.
// - a host read of modem_line_status clears all four change flags.
// - bit 7 is inverted carrier detect, or user_output_two in loopback.
// - bit 6 is inverted ring indicator, or user_output_one in loopback.
// - bit 5 is inverted peer ready, or terminal ready in loopback.
// - bit 4 is inverted clear to send, or request to send in loopback.
// - clear-to-send gates the transmitter only when control bit 5 is set.
// - with flow control on and pin high, finish current character, start none.
// - carrier, peer ready and clear-to-send flags set on either transition.
// - ring flag sets only when the ring pin rises from 0 to 1.
// - any set change flag raises the modem status interrupt; here only unmasked interrupt status bits do.
// - reset clears change flags; upper status bits keep following inputs.
//
// Decided for this implementation: the address map and register access over AHB-Lite.
`timescale 1ns/1ns
`include "mst_defines.vh"
module mst_modem_status_tracker (
    input  wire        CORE_CLK,
    input  wire        RST_N,
    // ahb-lite slave
    input  wire        HSEL,
    input  wire [31:0] HADDR,
    input  wire [1:0]  HTRANS,
    input  wire        HWRITE,
    input  wire [2:0]  HSIZE,
    input  wire [31:0] HWDATA,
    input  wire        HREADY,
    output reg         HREADYOUT,
    output reg  [31:0] HRDATA,
    output reg         HRESP,
    // modem lines, active low
    input  wire        CARRIER_DETECT_IN_N,
    input  wire        RING_INDICATOR_IN_N,
    input  wire        PEER_READY_IN_N,
    input  wire        CLEAR_TO_SEND_IN_N,
    output reg         TERMINAL_READY_OUT_N,
    output reg         REQUEST_TO_SEND_OUT_N,
    output reg         USER_OUTPUT_ONE_N,
    output reg         USER_OUTPUT_TWO_N,
    // transmitter handshake
    input  wire        TX_START_REQ,
    output reg         TX_START,
    // interrupt
    output reg         IRQ
);
    // synchronised pin levels (still active low)
    wire       carrier_n;
    wire       ring_n;
    wire       peer_n;
    wire       cts_n;

    // control, flag and interrupt state
    reg  [`MST_CT_WIDTH-1:0] control_q;
    reg  [3:0]  delta_q;
    reg  [3:0]  delta_d;
    reg  [3:0]  prev_q;
    reg  [3:0]  int_stat_q;
    reg  [3:0]  int_stat_d;
    reg  [3:0]  int_mask_q;
    reg  [2:0]  settle_q;
    reg  [3:0]  cur_status;
    reg  [3:0]  change;
    reg  [31:0] rd_mux;

    // address phase capture
    reg                   wr_pend_q;
    reg                   rd_pend_q;
    reg [`MST_ADDR_W-1:0] addr_q;

    wire       loopback;
    wire       auto_flow;
    wire       armed;
    wire       addr_take;
    wire       rd_status;
    wire       wr_int_stat;

    // one synchroniser per modem input
    mst_pin_sync #(.RESET_LEVEL(1'b1)) u_sync_carrier (
        .clk     (CORE_CLK),
        .rst_n   (RST_N),
        .pin     (CARRIER_DETECT_IN_N),
        .level_q (carrier_n)
    );
    mst_pin_sync #(.RESET_LEVEL(1'b1)) u_sync_ring (
        .clk     (CORE_CLK),
        .rst_n   (RST_N),
        .pin     (RING_INDICATOR_IN_N),
        .level_q (ring_n)
    );
    mst_pin_sync #(.RESET_LEVEL(1'b1)) u_sync_peer (
        .clk     (CORE_CLK),
        .rst_n   (RST_N),
        .pin     (PEER_READY_IN_N),
        .level_q (peer_n)
    );
    mst_pin_sync #(.RESET_LEVEL(1'b1)) u_sync_cts (
        .clk     (CORE_CLK),
        .rst_n   (RST_N),
        .pin     (CLEAR_TO_SEND_IN_N),
        .level_q (cts_n)
    );

    // change detection waits until the synchronisers hold the real pin
    // levels and prev_q has caught them; arming any earlier would report
    // a line already asserted at reset as a change
    assign loopback  = control_q[`MST_CT_LOOPBACK];
    assign auto_flow = control_q[`MST_CT_AUTO_FLOW];
    assign armed     = (settle_q == `MST_SETTLE_CYCLES);

    // an address phase is accepted when selected, active and hready high
    // hsize is not decoded: every transfer is taken as a whole word
    assign addr_take = HSEL & HREADY &
                       ((HTRANS == `MST_HTRANS_NONSEQ) | (HTRANS == `MST_HTRANS_SEQ));

    // the clearing read completes at the edge that loads HRDATA
    assign rd_status   = rd_pend_q & (addr_q == `MST_OFS_STATUS);
    assign wr_int_stat = wr_pend_q & (addr_q == `MST_OFS_INT_STAT);

    // live upper status bits: pins inverted, or control bits in loopback
    always @* begin
        if (loopback) begin
            cur_status[3] = control_q[`MST_CT_USER_TWO];
            cur_status[2] = control_q[`MST_CT_USER_ONE];
            cur_status[1] = control_q[`MST_CT_TERM_READY];
            cur_status[0] = control_q[`MST_CT_REQ_SEND];
        end else begin
            cur_status[3] = ~carrier_n;
            cur_status[2] = ~ring_n;
            cur_status[1] = ~peer_n;
            cur_status[0] = ~cts_n;
        end
    end

    // change detection; ring counts only the pin going low to high, which
    // is the status bit falling
    always @* begin
        change = 4'h0;
        if (armed) begin
            change[3] = cur_status[3] ^ prev_q[3];
            change[2] = prev_q[2] & ~cur_status[2];
            change[1] = cur_status[1] ^ prev_q[1];
            change[0] = cur_status[0] ^ prev_q[0];
        end
    end

    // change flags: clear on status read, but a new change wins
    always @* begin
        delta_d = delta_q;
        if (rd_status) begin
            delta_d = 4'h0;
        end
        delta_d = delta_d | change;
    end

    // interrupt status: set by each detected change, write one to clear, set wins
    always @* begin
        int_stat_d = int_stat_q;
        if (wr_int_stat) begin
            int_stat_d = int_stat_q & ~HWDATA[3:0];
        end
        int_stat_d = int_stat_d | change;
    end

    // settle counter and previous-level tracking
    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            settle_q <= 3'h0;
            prev_q   <= 4'h0;
        end else begin
            if (!armed) begin
                settle_q <= settle_q + 3'h1;
            end
            prev_q <= cur_status;
        end
    end

    // change flags and interrupt status
    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            delta_q    <= 4'h0;
            int_stat_q <= `MST_INT_STAT_RST;
        end else begin
            delta_q    <= delta_d;
            int_stat_q <= int_stat_d;
        end
    end

    // ahb address phase capture and ready generation
    // a read holds hready low for one cycle while hrdata is loaded; writes
    // finish in their first data cycle
    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= {`MST_ADDR_W{1'b0}};
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end else begin
            HRESP <= 1'b0;                                 // always okay
            if (rd_pend_q) begin
                rd_pend_q <= 1'b0;                         // read data loaded now
                HREADYOUT <= 1'b1;
            end else begin
                wr_pend_q <= addr_take & HWRITE;
                rd_pend_q <= addr_take & ~HWRITE;
                HREADYOUT <= ~(addr_take & ~HWRITE);       // one wait state on reads
                if (addr_take) begin
                    addr_q <= {HADDR[`MST_ADDR_W-1:2], 2'b00};
                end
            end
        end
    end

    // register read mux; only address bits 3:2 are decoded, so every word hits a register
    always @* begin
        rd_mux = 32'h0000_0000;
        case (addr_q)
            `MST_OFS_STATUS: begin
                rd_mux[7:0] = {cur_status, delta_q};
            end
            `MST_OFS_CONTROL: begin
                rd_mux[`MST_CT_WIDTH-1:0] = control_q;
            end
            `MST_OFS_INT_STAT: begin
                rd_mux[3:0] = int_stat_q;
            end
            `MST_OFS_INT_MASK: begin
                rd_mux[3:0] = int_mask_q;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // read data register, loaded in the wait cycle
    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            HRDATA <= 32'h0000_0000;
        end else if (rd_pend_q) begin
            HRDATA <= rd_mux;
        end
    end

    // writable registers, written in the data phase
    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            control_q  <= `MST_CONTROL_RST;
            int_mask_q <= `MST_INT_MASK_RST;
        end else if (wr_pend_q) begin
            case (addr_q)
                `MST_OFS_CONTROL: begin
                    control_q <= HWDATA[`MST_CT_WIDTH-1:0];
                end
                `MST_OFS_INT_MASK: begin
                    int_mask_q <= HWDATA[3:0];
                end
                default: begin
                    control_q <= control_q;
                end
            endcase
        end
    end

    // modem control outputs; held inactive while looped back internally
    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            TERMINAL_READY_OUT_N  <= 1'b1;
            REQUEST_TO_SEND_OUT_N <= 1'b1;
            USER_OUTPUT_ONE_N     <= 1'b1;
            USER_OUTPUT_TWO_N     <= 1'b1;
        end else begin
            TERMINAL_READY_OUT_N  <= loopback | ~control_q[`MST_CT_TERM_READY];
            REQUEST_TO_SEND_OUT_N <= loopback | ~control_q[`MST_CT_REQ_SEND];
            USER_OUTPUT_ONE_N     <= loopback | ~control_q[`MST_CT_USER_ONE];
            USER_OUTPUT_TWO_N     <= loopback | ~control_q[`MST_CT_USER_TWO];
        end
    end

    // transmit start grant: checked only when a new character would start,
    // so a character already on the line always runs to its end
    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            TX_START <= 1'b0;
        end else begin
            TX_START <= TX_START_REQ & ~(auto_flow & cts_n);
        end
    end

    // level interrupt from unmasked sticky bits
    // uses the next interrupt status so a new event reaches the pin sooner
    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(int_stat_d & int_mask_q);
        end
    end
endmodule

// File: hw/mst_defines.vh
// Purpose: offsets, field positions, reset values and timing counts for the
//          modem status tracker
// Assumes: 32-bit AHB-Lite data, one register per aligned word
// Notes:   included by bare name; definitions only
`ifndef MST_DEFINES_VH
`define MST_DEFINES_VH

// register byte offsets (low address bits decoded)
`define MST_ADDR_W          4
`define MST_OFS_STATUS      4'h0
`define MST_OFS_CONTROL     4'h4
`define MST_OFS_INT_STAT    4'h8
`define MST_OFS_INT_MASK    4'hC

// modem_line_status fields
`define MST_ST_CARRIER      7
`define MST_ST_RING         6
`define MST_ST_PEER         5
`define MST_ST_CTS          4
`define MST_DL_CARRIER      3
`define MST_DL_RING         2
`define MST_DL_PEER         1
`define MST_DL_CTS          0

// modem_control_register fields
`define MST_CT_TERM_READY   0
`define MST_CT_REQ_SEND     1
`define MST_CT_USER_ONE     2
`define MST_CT_USER_TWO     3
`define MST_CT_LOOPBACK     4
`define MST_CT_AUTO_FLOW    5
`define MST_CT_WIDTH        6

// reset values
`define MST_CONTROL_RST     6'h00
`define MST_INT_MASK_RST    4'hF
`define MST_INT_STAT_RST    4'h0

// ahb encodings
`define MST_HTRANS_NONSEQ   2'b10
`define MST_HTRANS_SEQ      2'b11

// cycles after reset during which change detection is held off while the
// pin synchronisers settle; the filter moves at the fourth edge at the
// latest and the previous-level register needs one edge more
`define MST_SETTLE_CYCLES   3'h5

`endif

// File: hw/mst_pin_sync.v
// Purpose: bring one asynchronous pin into the CORE_CLK domain
// Assumes: pin idles high (inactive level of an active-low modem line)
// Notes:   four flops; the output level moves only when stages two and
//          three agree, so a single metastable sample never reaches logic
`timescale 1ns/1ns
module mst_pin_sync #(
    parameter RESET_LEVEL = 1'b1
) (
    input  wire clk,
    input  wire rst_n,
    input  wire pin,
    output reg  level_q
);
    reg s1_q;
    reg s2_q;
    reg s3_q;

    // three-stage chain plus agreement filter
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q    <= RESET_LEVEL;
            s2_q    <= RESET_LEVEL;
            s3_q    <= RESET_LEVEL;
            level_q <= RESET_LEVEL;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_q <= s3_q;
            end
        end
    end
endmodule

// File: dv/mst_checker.sv
// Purpose: port assertions for the modem status tracker
// Assumes: one clock, async active-low reset
// Notes:   mask and control are shadowed from bus writes
`timescale 1ns/1ns
`include "mst_defines.vh"
module mst_checker (
    input wire logic        CORE_CLK,
    input wire logic        RST_N,
    input wire logic        HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic        HREADY,
    input wire logic        HREADYOUT,
    input wire logic        CARRIER_DETECT_IN_N,
    input wire logic        RING_INDICATOR_IN_N,
    input wire logic        PEER_READY_IN_N,
    input wire logic        CLEAR_TO_SEND_IN_N,
    input wire logic        TX_START_REQ,
    input wire logic        TX_START,
    input wire logic        IRQ
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_N);
    logic       wr_q;
    logic [3:0] wa_q;
    logic [3:0] mask_q;
    logic       loop_q;
    logic       flow_q;
    logic [3:0] pins_q;
    logic [3:0] quiet_q;
    wire        take = HSEL && HREADY && HTRANS[1];
    wire  [3:0] pins = {CARRIER_DETECT_IN_N, RING_INDICATOR_IN_N,
                        PEER_READY_IN_N, CLEAR_TO_SEND_IN_N};

    // shadow writes; count cycles with no pin move and no transfer
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_q    <= 1'b0;
            wa_q    <= 4'h0;
            mask_q  <= `MST_INT_MASK_RST;
            loop_q  <= 1'b0;
            flow_q  <= 1'b0;
            pins_q  <= 4'hF;
            quiet_q <= 4'h0;
        end else begin
            if (HREADY) begin
                wr_q <= take && HWRITE;
                wa_q <= HADDR[3:0];
            end
            if (wr_q && HREADY && wa_q == `MST_OFS_INT_MASK)
                mask_q <= HWDATA[3:0];
            if (wr_q && HREADY && wa_q == `MST_OFS_CONTROL) begin
                loop_q <= HWDATA[`MST_CT_LOOPBACK];
                flow_q <= HWDATA[`MST_CT_AUTO_FLOW];
            end
            pins_q <= pins;
            if (pins != pins_q || take)
                quiet_q <= 4'h0;
            else if (quiet_q != 4'hF)
                quiet_q <= quiet_q + 4'h1;
        end
    end

    sequence s_rd_wait;
        !HREADYOUT ##1 HREADYOUT;
    endsequence
    sequence s_cts_high;
        CLEAR_TO_SEND_IN_N [*8];
    endsequence
    sequence s_cts_low;
        !CLEAR_TO_SEND_IN_N [*8];
    endsequence

    a_read_wait: assert property (take && !HWRITE |=> s_rd_wait)
        else $error("read not one wait state");
    a_flow_stop: assert property (s_cts_high ##0 flow_q |=> !TX_START)
        else $error("start while flow on and pin high");
    a_cts_grant: assert property (s_cts_low ##0 TX_START_REQ |=> TX_START)
        else $error("start refused with pin low");
    a_start_needs_req: assert property (!TX_START_REQ |=> !TX_START)
        else $error("start without request");
    a_carrier_irq: assert property ($changed(CARRIER_DETECT_IN_N)
        && mask_q[3] && !loop_q |-> ##[1:10] IRQ)
        else $error("carrier move raised no irq");
    a_ring_irq: assert property ($rose(RING_INDICATOR_IN_N)
        && mask_q[2] && !loop_q |-> ##[1:10] IRQ)
        else $error("ring release raised no irq");
    a_quiet_irq: assert property ($rose(IRQ) |-> quiet_q < 4'd12)
        else $error("irq with no cause");
    a_masked_quiet: assert property ((mask_q == 4'h0) [*2] |-> !IRQ)
        else $error("irq while all masked");
endmodule

bind mst_modem_status_tracker mst_checker u_chk (.CORE_CLK, .RST_N, .HSEL, .HADDR,
    .HTRANS, .HWRITE, .HWDATA, .HREADY, .HREADYOUT, .CARRIER_DETECT_IN_N,
    .RING_INDICATOR_IN_N, .PEER_READY_IN_N, .CLEAR_TO_SEND_IN_N, .TX_START_REQ,
    .TX_START, .IRQ);

// File: dv/mst_modem_model.sv
// Purpose: behavioural modem on the four active-low status lines
// Assumes: bench says which lines are asserted, [3:0] = carrier..cts
// Notes:   lines move just after a rising edge and idle high
`timescale 1ns/1ns
module mst_modem_model (
    input  wire logic       clk,
    input  wire logic [3:0] want,
    output logic      [3:0] line_n
);
    // lines start inactive
    initial line_n = 4'hF;
    // an asserted line is driven low
    always @(posedge clk) begin
        line_n <= ~want;
    end
endmodule

// File: dv/mst_modem_status_tracker_tb_top.sv
// Purpose: self-checking bench for the modem status tracker
// Assumes: one AHB-Lite master, modem model on the pins
// Notes:   every exit goes through summarize
`timescale 1ns/1ns
`include "mst_defines.vh"
module mst_modem_status_tracker_tb_top;
    logic        clk;
    logic        rst_n  = 1'b0;
    logic        hsel   = 1'b0;
    logic [31:0] haddr  = 32'h0;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        tx_req = 1'b0;
    logic [3:0]  want   = 4'b1000;
    logic [3:0]  nw;
    logic [3:0]  lp [2] = '{4'b0101, 4'b1010};
    logic [31:0] r;
    logic [31:0] acc;
    wire         hreadyout;
    wire  [31:0] hrdata;
    wire         tx_start;
    wire         irq;
    wire         hresp;
    wire  [3:0]  pin_n;
    wire  [3:0]  out_n;
    int          errors   = 0;
    int          compares = 0;

    mst_modem_model u_modem (.clk(clk), .want(want), .line_n(pin_n));
    mst_modem_status_tracker DUT (.CORE_CLK(clk), .RST_N(rst_n), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010),
        .HWDATA(hwdata), .HREADY(hreadyout), .HREADYOUT(hreadyout),
        .HRDATA(hrdata), .HRESP(hresp), .CARRIER_DETECT_IN_N(pin_n[3]),
        .RING_INDICATOR_IN_N(pin_n[2]), .PEER_READY_IN_N(pin_n[1]),
        .CLEAR_TO_SEND_IN_N(pin_n[0]), .TERMINAL_READY_OUT_N(out_n[0]),
        .REQUEST_TO_SEND_OUT_N(out_n[1]), .USER_OUTPUT_ONE_N(out_n[2]),
        .USER_OUTPUT_TWO_N(out_n[3]), .TX_START_REQ(tx_req),
        .TX_START(tx_start), .IRQ(irq));

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // one single transfer; read data taken at the closing edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= {28'h000_0000, a};
        hwrite <= w;
        htrans <= `MST_HTRANS_NONSEQ;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask

    // move the lines, read flags twice, then clear the interrupt
    task automatic wiggle(input logic [3:0] w, input logic [3:0] flg);
        want <= w;
        repeat (12) @(posedge clk);
        chk("irq", {31'h0, |flg}, {31'h0, irq});
        bus(1'b0, `MST_OFS_STATUS, 32'h0);
        chk("status", {24'h0, w, flg}, r);
        bus(1'b0, `MST_OFS_STATUS, 32'h0);
        chk("status reread", {24'h0, w, 4'h0}, r);
        bus(1'b1, `MST_OFS_INT_STAT, 32'h0000_000F);
    endtask

    task automatic summarize();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // watchdog, far beyond the few hundred cycles needed
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        summarize();
    end

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        bus(1'b0, `MST_OFS_STATUS, 32'h0);
        chk("status", 32'h0000_0080, r);
        bus(1'b0, `MST_OFS_INT_MASK, 32'h0);
        chk("mask", 32'h0000_000F, r);
        $display("test reset done");
        // cts, peer and ring asserted then released, carrier released then reasserted; ring counts only on release
        for (int k = 0; k < 8; k++) begin
            nw = want ^ (4'h1 << k[1:0]);
            wiggle(nw, (k[1:0] == 2'd2 && nw[2]) ? 4'h0 : 4'h1 << k[1:0]);
        end
        $display("test flags done");
        // carrier moves while reads stream back to back; the four lead-ins
        // walk the flag's setting edge across every phase of a read
        for (int d = 0; d < 4; d++) begin
            want <= want ^ 4'b1000;
            repeat (d) @(posedge clk);
            acc = 32'h0;
            repeat (5) begin
                bus(1'b0, `MST_OFS_STATUS, 32'h0);
                acc = acc | r;
            end
            chk("flag in read", 32'h0000_0008, acc & 32'h0000_000F);
        end
        $display("test read race done");
        // loopback: status follows control bits, outputs park high
        foreach (lp[i]) begin
            bus(1'b1, `MST_OFS_CONTROL, {26'h0, 2'b01, lp[i]});
            bus(1'b0, `MST_OFS_STATUS, 32'h0);
            chk("loop status", {24'h0, lp[i][3], lp[i][2], lp[i][0], lp[i][1], 4'h0},
                r & 32'h0000_00F0);
            chk("loop outs", 32'h0000_000F, {28'h0, out_n});
            bus(1'b0, `MST_OFS_CONTROL, 32'h0);
            chk("control", {26'h0, 2'b01, lp[i]}, r);
        end
        $display("test loopback done");
        // gate acts only with auto flow on
        bus(1'b1, `MST_OFS_CONTROL, 32'h0000_000F);
        tx_req <= 1'b1;
        repeat (3) @(posedge clk);
        chk("start flow off", 32'h1, {31'h0, tx_start});
        chk("modem outs", 32'h0, {28'h0, out_n});
        bus(1'b1, `MST_OFS_CONTROL, 32'h0000_0020);
        repeat (3) @(posedge clk);
        chk("start flow on", 32'h0, {31'h0, tx_start});
        want <= 4'b0001;
        repeat (10) @(posedge clk);
        chk("start cts low", 32'h1, {31'h0, tx_start});
        $display("test flow done");
        // masked event stays pending until unmasked
        bus(1'b0, `MST_OFS_STATUS, 32'h0);
        bus(1'b1, `MST_OFS_INT_STAT, 32'h0000_000F);
        bus(1'b1, `MST_OFS_INT_MASK, 32'h0);
        want <= 4'b0011;
        repeat (12) @(posedge clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        bus(1'b0, `MST_OFS_INT_STAT, 32'h0);
        chk("int status", 32'h0000_0002, r);
        bus(1'b1, `MST_OFS_INT_MASK, 32'h0000_0002);
        repeat (2) @(posedge clk);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        bus(1'b1, `MST_OFS_INT_STAT, 32'h0000_0002);
        repeat (2) @(posedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        $display("test mask done");
        // reset in mid-run with a carrier flag pending
        want <= 4'b1011;
        repeat (12) @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        bus(1'b0, `MST_OFS_STATUS, 32'h0);
        chk("status after reset", 32'h0000_00B0, r);
        $display("test mid reset done");
        summarize();
    end
endmodule
